// File: wdt_pkg.sv
// Constants shared by the watchdog and reset-flag block
package wdt_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 10000;
    localparam int RSTD_TIME_NS   = 1000;
    localparam int RSTD_CYCLES    = (RSTD_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int LVR_TIME_NS    = 120000;
    localparam int LVR_CYCLES     = (LVR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int KEY_DEBOUNCE   = 2;
    localparam int SYSDIV         = 4;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_WDCTRL = 8'h00;
    localparam logic [7:0] OFS_SMOD   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQST  = 8'h0C;
    localparam logic [7:0] OFS_IRQMSK = 8'h10;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int KEY_HI = 7;
    localparam int KEY_LO = 3;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 0;
    localparam logic [4:0] KEY_DISABLE   = 5'h15;
    localparam logic [4:0] KEY_ENABLE    = 5'h0A;
    localparam logic [7:0] WDCTRL_POR    = 8'h53;
    localparam int SMOD_KEYFAULT  = 0;
    localparam int SMOD_LEVELCODE = 1;
    localparam int SMOD_DROOP     = 2;
    localparam int SMOD_IDLEKEEP  = 7;
    localparam int ST_EXPIRY      = 0;
    localparam int ST_POWERDOWN   = 1;

    // Interrupt event bits
    localparam int EV_EXPIRY   = 0;
    localparam int EV_KEYFAULT = 1;
    localparam int EV_DROOP    = 2;
    localparam int EV_EXTPIN   = 3;
    localparam int EV_N        = 4;

    localparam int CNT_W = 18;

endpackage

// File: pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Pin and filtered level
    input  wire logic pinIn,
    output logic      levelOut
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            levelOut   <= 1'b0;
        end
        else
        begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            // A change counts only once two late stages agree
            if (stage2_reg == stage3_reg)
                levelOut <= stage3_reg;
        end
    end
endmodule

// File: tick_qualifier.sv
// Counts qualifying ticks while a condition holds and fires once at the limit
`timescale 1ns/1ps
module tick_qualifier
#(
    parameter int LIMIT = 2,
    parameter int CW    = 16
)
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Condition, tick and result
    input  wire logic cond,
    input  wire logic tick,
    output logic      fire
);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);
    logic [CW-1:0] count_reg;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_reg <= '0;
            fire      <= 1'b0;
        end
        else
        begin
            fire <= 1'b0;
            if (!cond)
                count_reg <= '0;
            else if (tick && count_reg != LIM)
            begin
                count_reg <= count_reg + 1'b1;
                // Saturates, so a held condition fires only once
                fire      <= (count_reg + 1'b1) == LIM;
            end
        end
    end
endmodule

// File: watchdog_with_reset_flags.sv
// Watchdog timer with reset sources, reset-cause flags and Wishbone registers
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module watchdog_with_reset_flags
#(
    parameter int DROOP_CYCLES = wdt_pkg::LVR_CYCLES
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Core events
    input  wire logic        clearDogInstr,
    input  wire logic        haltInstr,
    input  wire logic        sleepMode,
    // Configuration straps and pins
    input  wire logic        optAlwaysOn,
    input  wire logic        optClkSub,
    input  wire logic        subClkPin,
    input  wire logic        lowSpeedOscPin,
    input  wire logic        externalResetPin_n,
    input  wire logic        supplyLowPin,
    // Reset and status outputs
    output logic             coreReset,
    output logic             pcSpClear,
    output logic             portPresetHigh,
    output logic             idleSysclkKeep,
    output logic             irq
);
    import wdt_pkg::*;

    localparam int RW = $clog2(RSTD_CYCLES + 1);
    localparam logic [RW-1:0] RSTD_LOAD = RW'(RSTD_CYCLES);

    // ------------------------------------------------------------
    // Period decode
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] periodLast(input logic [2:0] sel);
        logic [4:0] shift;
        shift = 5'h00;
        unique case (sel)
            3'h0: shift = 5'h08;
            3'h1: shift = 5'h0A;
            3'h2: shift = 5'h0C;
            3'h3: shift = 5'h0E;
            3'h4: shift = 5'h0F;
            3'h5: shift = 5'h10;
            3'h6: shift = 5'h11;
            3'h7: shift = 5'h12;
        endcase
        periodLast = CNT_W'(({1'b0, {CNT_W{1'b1}}} >> (5'h12 - shift)));
    endfunction

    function automatic logic keyValid(input logic [4:0] key);
        keyValid = (key == KEY_ENABLE) || (key == KEY_DISABLE);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]       wdCtrl_reg;
    logic             keyFault_reg;
    logic             droop_reg;
    logic             idleKeep_reg;
    logic             expiry_reg;
    logic             powerdown_reg;
    logic [EV_N-1:0]  irqSt_reg;
    logic [EV_N-1:0]  irqMsk_reg;
    logic [CNT_W-1:0] count_reg;
    logic [1:0]       div_reg;
    logic [RW-1:0]    hold_reg;
    logic             strapDone_reg;
    logic             alwaysOn_reg;
    logic             clkSub_reg;
    logic             subPrev_reg;
    logic             oscPrev_reg;
    logic             extPrev_reg;
    logic             subLvl;
    logic             oscLvl;
    logic             extLvl;
    logic             lowLvl;
    logic             wdTick;
    logic             oscTick;
    logic             dogOn;
    logic             overflow;
    logic             keyFire;
    logic             droopFire;
    logic             extFall;
    logic             fullReset;
    logic             wrStb;
    logic [EV_N-1:0]  events;

    // ------------------------------------------------------------
    // Pin synchronisers and qualifiers
    // ------------------------------------------------------------
    pin_sync uSubSync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .pinIn    (subClkPin),
        .levelOut (subLvl)
    );
    pin_sync uOscSync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .pinIn    (lowSpeedOscPin),
        .levelOut (oscLvl)
    );
    pin_sync uExtSync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .pinIn    (externalResetPin_n),
        .levelOut (extLvl)
    );
    pin_sync uLowSync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .pinIn    (supplyLowPin),
        .levelOut (lowLvl)
    );

    // The third slow-clock rise after a fault lands two to three periods later
    tick_qualifier #(.LIMIT(KEY_DEBOUNCE + 1), .CW(2)) uKeyDebounce (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .cond    (!keyValid(wdCtrl_reg[KEY_HI:KEY_LO])),
        .tick    (oscTick),
        .fire    (keyFire)
    );

    tick_qualifier #(.LIMIT(DROOP_CYCLES), .CW(24)) uDroopQual (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .cond    (lowLvl),
        .tick    (1'b1),
        .fire    (droopFire)
    );

    // ------------------------------------------------------------
    // Edge detection and straps
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            subPrev_reg <= 1'b0;
            oscPrev_reg <= 1'b0;
            // Sync output resets low; a high here would fake a pin fall
            extPrev_reg <= 1'b0;
        end
        else
        begin
            subPrev_reg <= subLvl;
            oscPrev_reg <= oscLvl;
            extPrev_reg <= extLvl;
        end
    end

    assign oscTick = oscLvl && !oscPrev_reg;
    assign extFall = !extLvl && extPrev_reg;

    // Options are static; caught once just after reset release
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strapDone_reg <= 1'b0;
            alwaysOn_reg  <= 1'b0;
            clkSub_reg    <= 1'b0;
        end
        else if (!strapDone_reg)
        begin
            strapDone_reg <= 1'b1;
            alwaysOn_reg  <= optAlwaysOn;
            clkSub_reg    <= optClkSub;
        end
    end

    // ------------------------------------------------------------
    // Watchdog clock
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end

    assign wdTick = clkSub_reg ? (subLvl && !subPrev_reg)
                               : (div_reg == 2'(SYSDIV - 1));

    assign dogOn = alwaysOn_reg
                || (wdCtrl_reg[KEY_HI:KEY_LO] != KEY_DISABLE);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    assign overflow = dogOn && wdTick
                   && (count_reg == periodLast(wdCtrl_reg[SEL_HI:SEL_LO]));

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            count_reg <= '0;
        else if (clearDogInstr)
            count_reg <= '0;
        else if (haltInstr)
            count_reg <= '0;
        else if (coreReset || keyFire || overflow)
            count_reg <= '0;
        else if (dogOn && wdTick)
            count_reg <= count_reg + 1'b1;
    end

    // ------------------------------------------------------------
    // Reset generation
    // ------------------------------------------------------------
    assign fullReset = keyFire || droopFire || (overflow && !sleepMode);

    // Pin low holds the core; the delay reloads until the pin returns high
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_reg  <= RSTD_LOAD;
            coreReset <= 1'b1;
        end
        else if (!extLvl || fullReset)
        begin
            hold_reg  <= RSTD_LOAD;
            coreReset <= 1'b1;
        end
        else if (hold_reg != '0)
        begin
            hold_reg  <= hold_reg - 1'b1;
            coreReset <= 1'b1;
        end
        else
            coreReset <= 1'b0;
    end

    // Only the sleeping core sees the partial clear
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            pcSpClear <= 1'b0;
        else
            pcSpClear <= overflow && sleepMode;
    end

    // Ports stay preset high until the first power-on hold ends
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            portPresetHigh <= 1'b1;
        else if (!coreReset)
            portPresetHigh <= 1'b0;
    end

    // ------------------------------------------------------------
    // Bus
    // ------------------------------------------------------------
    assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        begin
            unique case (wb_adr_i)
                OFS_WDCTRL: wb_dat_o <= {24'h000000, wdCtrl_reg};
                OFS_SMOD:   wb_dat_o <= {24'h000000, idleKeep_reg, 4'h0,
                                         droop_reg, 1'b0, keyFault_reg};
                OFS_STATUS: wb_dat_o <= {30'h0000_0000, powerdown_reg, expiry_reg};
                OFS_IRQST:  wb_dat_o <= {28'h000_0000, irqSt_reg};
                OFS_IRQMSK: wb_dat_o <= {28'h000_0000, irqMsk_reg};
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // A key fault restores the power-on value, ending the fault
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wdCtrl_reg <= WDCTRL_POR;
        else if (keyFire)
            wdCtrl_reg <= WDCTRL_POR;
        else if (wrStb && wb_adr_i == OFS_WDCTRL)
            wdCtrl_reg <= wb_dat_i[7:0];
    end

    // ------------------------------------------------------------
    // Mode register and reset-cause flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            keyFault_reg <= 1'b0;
            droop_reg    <= 1'b0;
            idleKeep_reg <= 1'b0;
        end
        else
        begin
            if (keyFire)
                keyFault_reg <= 1'b1;
            else if (wrStb && wb_adr_i == OFS_SMOD && !wb_dat_i[SMOD_KEYFAULT])
                keyFault_reg <= 1'b0;
            if (droopFire)
                droop_reg <= 1'b1;
            else if (wrStb && wb_adr_i == OFS_SMOD && !wb_dat_i[SMOD_DROOP])
                droop_reg <= 1'b0;
            if (wrStb && wb_adr_i == OFS_SMOD)
                idleKeep_reg <= wb_dat_i[SMOD_IDLEKEEP];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            idleSysclkKeep <= 1'b0;
        else
            idleSysclkKeep <= idleKeep_reg;
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            expiry_reg    <= 1'b0;
            powerdown_reg <= 1'b0;
        end
        else
        begin
            if (overflow)
                expiry_reg <= 1'b1;
            else if (clearDogInstr || haltInstr)
                expiry_reg <= 1'b0;
            if (haltInstr)
                powerdown_reg <= 1'b1;
            else if (clearDogInstr)
                powerdown_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb
    begin
        events              = '0;
        events[EV_EXPIRY]   = overflow;
        events[EV_KEYFAULT] = keyFire;
        events[EV_DROOP]    = droopFire;
        events[EV_EXTPIN]   = extFall;
    end

    // Set wins over a same-cycle write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < EV_N; gi++)
        begin : gEv
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    irqSt_reg[gi] <= 1'b0;
                else if (events[gi])
                    irqSt_reg[gi] <= 1'b1;
                else if (wrStb && wb_adr_i == OFS_IRQST && wb_dat_i[gi])
                    irqSt_reg[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            irqMsk_reg <= '0;
        else if (wrStb && wb_adr_i == OFS_IRQMSK)
            irqMsk_reg <= wb_dat_i[EV_N-1:0];
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= |(irqSt_reg & irqMsk_reg);
    end

endmodule

// File: watchdog_with_reset_flags_checker.sv
// Port-level assertions for the watchdog block
`timescale 1ns/1ps
module watchdog_with_reset_flags_checker
(
    // Clock, reset and bus
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic       wb_ack_o,
    // Core events, pins and results
    input wire logic       clearDogInstr,
    input wire logic       haltInstr,
    input wire logic       sleepMode,
    input wire logic       externalResetPin_n,
    input wire logic       coreReset,
    input wire logic       pcSpClear,
    input wire logic       portPresetHigh,
    input wire logic       idleSysclkKeep
);
    import wdt_pkg::*;
    logic        smodWr;
    logic [15:0] sinceClr;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    assign smodWr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_SMOD);
    // Saturating age of the count; saturation keeps long idle runs from wrapping
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            sinceClr <= 16'h0000;
        else if (clearDogInstr | haltInstr | coreReset)
            sinceClr <= 16'h0000;
        else if (sinceClr != 16'hFFFF)
            sinceClr <= sinceClr + 16'h0001;
    end
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_ackdrop; wb_ack_o |=> !wb_ack_o; endproperty
    a_ackdrop: assert property (p_ackdrop) else $error("ack longer than one cycle");
    property p_idle; $changed(idleSysclkKeep) |-> $past(smodWr) || $past(smodWr, 2); endproperty
    a_idle: assert property (p_idle) else $error("idle keep moved without a write");
    property p_portfall; $fell(portPresetHigh) |-> !coreReset; endproperty
    a_portfall: assert property (p_portfall) else $error("port preset fell in reset");
    property p_extpin; $fell(externalResetPin_n) |-> ##[1:8] coreReset; endproperty
    a_extpin: assert property (p_extpin) else $error("pin low gave no reset");
    property p_hold; $fell(coreReset) |-> $past(externalResetPin_n, 100); endproperty
    a_hold: assert property (p_hold) else $error("reset ended too soon");
    property p_pcsp; pcSpClear |-> ($past(sleepMode) && !coreReset) ##1 !pcSpClear; endproperty
    a_pcsp: assert property (p_pcsp) else $error("bad sleep overflow pulse");
    property p_period; pcSpClear |-> sinceClr > 16'h03E8; endproperty
    a_period: assert property (p_period) else $error("overflow too early");
endmodule

// File: watchdog_with_reset_flags_tb_top.sv
// Self-checking bench for the watchdog with reset flags
`timescale 1ns/1ps
module watchdog_with_reset_flags_tb_top;
    import wdt_pkg::*;
    logic        ref_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        clearDogInstr, haltInstr, sleepMode, optAlwaysOn, optClkSub;
    logic        subClkPin, lowSpeedOscPin, externalResetPin_n, supplyLowPin;
    logic        coreReset, pcSpClear, portPresetHigh, idleSysclkKeep, irq;
    logic [4:0]  div;
    int          n_fail, cmp_count;
    // Short droop qualifier keeps the run brief
    watchdog_with_reset_flags #(.DROOP_CYCLES(20)) watchdog_with_reset_flags_inst (.*);
    // ----------------------------------------
    // Clocks and tasks
    // ----------------------------------------
    always #5 ref_clk = ~ref_clk;
    // Sub clock period 16 cycles, slow oscillator 32
    always @(posedge ref_clk)
    begin
        div <= div + 5'h01;
        subClkPin <= div[3];
        lowSpeedOscPin <= div[4];
    end
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tmo;
        n_fail++;
        stop_test;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wbx(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int i;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++)
            @(posedge ref_clk);
        if (i == 50)
            tmo;
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wbx(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] q;
        wbx(1'b0, a, 8'h00, q);
        chk(q, e, nm);
    endtask
    // One-cycle halt or clear-watchdog pulse
    task automatic pz(input logic h);
        @(posedge ref_clk);
        haltInstr <= h;
        clearDogInstr <= !h;
        @(posedge ref_clk);
        haltInstr <= 1'b0;
        clearDogInstr <= 1'b0;
    endtask
    // Edges until: 0 sleep overflow, 1 reset asserted, 2 reset released
    task automatic wt(input int s, input int lim, input bit must, output int n);
        for (n = 0; n < lim; n++)
        begin
            @(posedge ref_clk);
            if ((s == 0 && pcSpClear === 1'b1) || (s == 1 && coreReset === 1'b1)
                || (s == 2 && coreReset === 1'b0))
                break;
        end
        if (must && n == lim)
            tmo;
    endtask
    function automatic int per(input int c);
        int e[8] = '{8, 10, 12, 14, 15, 16, 17, 18};
        return 4 << e[c];
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int n, k;
        logic [31:0] r;
        {ref_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, clearDogInstr, haltInstr} = '0;
        {sleepMode, optAlwaysOn, optClkSub, supplyLowPin, n_fail, cmp_count} = '0;
        {wb_adr_i, wb_dat_i, div} = '0;
        wb_sel_i = 4'h1;
        externalResetPin_n = 1'b1;
        r = $urandom(80);
        repeat (20) @(posedge ref_clk);
        chk(portPresetHigh, 1'b1, "ports");
        arst_n <= 1'b1;
        wt(2, 400, 1, n);
        rc(OFS_WDCTRL, 8'h53, "ctrl");
        rc(OFS_SMOD, 8'h00, "mode");
        rc(OFS_STATUS, 8'h00, "status");
        rc(OFS_IRQMSK, 8'h00, "mask");
        rc(8'h1C, 8'h00, "unmapped");
        chk(portPresetHigh, 1'b0, "ports");
        repeat (4)
        begin
            r = $urandom;
            wr(OFS_SMOD, r[7:0]);
            rc(OFS_SMOD, {r[7], 7'h00}, "mode");
            chk(idleSysclkKeep, r[7], "idle");
        end
        wr(OFS_SMOD, 8'h00);
        pz(1'b1);
        rc(OFS_STATUS, 8'h02, "status");
        pz(1'b0);
        rc(OFS_STATUS, 8'h00, "status");
        sleepMode <= 1'b1;
        wr(OFS_WDCTRL, {KEY_DISABLE, 3'h0});
        pz(1'b0);
        wt(0, 1500, 0, n);
        chk(n, 1500, "frozen");
        for (k = 0; k < 3; k++)
        begin
            wr(OFS_WDCTRL, {KEY_ENABLE, k[2:0]});
            pz(1'b0);
            wt(0, 500, 0, n);
            chk(n, 500, "early");
            pz(k == 1);
            wt(0, per(k) + 50, 1, n);
            chk(n > per(k) - 10 && n < per(k) + 10, 1'b1, "period");
            chk(coreReset, 1'b0, "core");
            rc(OFS_STATUS, {6'h00, k == 1, 1'b1}, "status");
        end
        chk(irq, 1'b0, "irq");
        // A write without its byte lane must not land
        wb_sel_i <= 4'h0;
        wr(OFS_IRQMSK, 8'h0F);
        wb_sel_i <= 4'h1;
        rc(OFS_IRQMSK, 8'h00, "nosel");
        wr(OFS_IRQMSK, 8'h01);
        rc(OFS_IRQMSK, 8'h01, "mask");
        chk(irq, 1'b1, "irq");
        wr(OFS_IRQST, 8'h01);
        rc(OFS_IRQST, 8'h00, "irqst");
        chk(irq, 1'b0, "irq");
        sleepMode <= 1'b0;
        wr(OFS_WDCTRL, {KEY_ENABLE, 3'h0});
        pz(1'b0);
        wt(1, 1200, 1, n);
        chk(n > 1000, 1'b1, "reset");
        wt(2, 300, 1, n);
        rc(OFS_STATUS, 8'h01, "status");
        wr(OFS_WDCTRL, 8'h53);
        pz(1'b0);
        wr(OFS_IRQST, 8'h0F);
        wr(OFS_WDCTRL, 8'hFB);
        wt(1, 300, 1, n);
        chk(n > 64 && n < 100, 1'b1, "debounce");
        wt(2, 300, 1, n);
        rc(OFS_SMOD, 8'h01, "mode");
        rc(OFS_WDCTRL, 8'h53, "ctrl");
        rc(OFS_IRQST, 8'h02, "irqst");
        wr(OFS_SMOD, 8'h01);
        rc(OFS_SMOD, 8'h01, "mode");
        wr(OFS_SMOD, 8'h00);
        rc(OFS_SMOD, 8'h00, "mode");
        externalResetPin_n <= 1'b0;
        wt(1, 20, 1, n);
        repeat (30) @(posedge ref_clk);
        externalResetPin_n <= 1'b1;
        wt(2, 400, 1, n);
        chk(n >= RSTD_CYCLES, 1'b1, "delay");
        supplyLowPin <= 1'b1;
        repeat (10) @(posedge ref_clk);
        supplyLowPin <= 1'b0;
        wt(1, 40, 0, n);
        chk(n, 40, "dip");
        supplyLowPin <= 1'b1;
        wt(1, 60, 1, n);
        chk(n >= 20, 1'b1, "droop");
        supplyLowPin <= 1'b0;
        wt(2, 400, 1, n);
        rc(OFS_SMOD, 8'h04, "mode");
        // Straps are read once after reset, so a second power-on changes them
        arst_n <= 1'b0;
        optAlwaysOn <= 1'b1;
        optClkSub <= 1'b1;
        sleepMode <= 1'b1;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        wt(2, 400, 1, n);
        rc(OFS_STATUS, 8'h00, "status");
        wr(OFS_WDCTRL, {KEY_DISABLE, 3'h0});
        pz(1'b0);
        wt(0, 6000, 1, n);
        chk(n > 4000, 1'b1, "subclock");
        stop_test;
    end
endmodule
bind watchdog_with_reset_flags watchdog_with_reset_flags_checker
    watchdog_with_reset_flags_checker_inst (.*);
